/* File: verilog/ocr_pkg.sv */
// Package for the overcurrent fault response block: config layout,
// action codes, retry codes, reset values and timing constants.
// Assumes a single 10 MHz clock domain.
package ocr_pkg;
   // Configuration field positions
   localparam int CFG_ACTION_MSB = 7;
   localparam int CFG_ACTION_LSB = 6;
   localparam int CFG_RETRY_MSB = 5;
   localparam int CFG_RETRY_LSB = 3;
   localparam int CFG_TIME_MSB = 2;
   localparam int CFG_TIME_LSB = 0;
   // Value after reset of the configuration (plain choice)
   localparam logic [7:0] CFG_RESET = 8'h00;
   // Action codes
   localparam logic [1:0] ACT_IGNORE = 2'h0;
   localparam logic [1:0] ACT_CC_LV = 2'h1;
   localparam logic [1:0] ACT_DELAY = 2'h2;
   localparam logic [1:0] ACT_DISABLE = 2'h3;
   // Retry codes
   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;
   // Highest multiplier code that is documented; above it saturates
   localparam logic [2:0] TIME_CODE_MAX = 3'h4;
   // Time unit, in microseconds, and its length in clock cycles
   localparam int CLK_PERIOD_NS = 100;
   localparam int TIME_UNIT_US = 10;
   localparam int UNIT_CYCLES = (TIME_UNIT_US * 1000) / CLK_PERIOD_NS;
   localparam int CNT_W = 16;

   // Status carried out of the block
   typedef struct packed {
      logic output_en;
      logic current_limit;
      logic latched_off;
   } ocr_status_s;

   typedef enum logic [3:0] {
      ST_RUN = 4'b0001,
      ST_LIMIT = 4'b0010,
      ST_OFF = 4'b0100,
      ST_WAIT = 4'b1000
   } ocr_state_e;
endpackage

/* File: verilog/ocr_fault_response.sv */
// Overcurrent fault response controller: takes the configuration byte
// and fault indications, and drives output enable and current limit.
// Assumes fault inputs are synchronous to mclk_in and already debounced.
`timescale 1ns/1ps
// How it works
// - Ignore action: run forever with current clamped at the limit.
// - Action 01: clamp while voltage is above cutoff; else shut down, retry.
// - Action 10: clamp current for the programmed delay time.
// - Action 10: still limiting after delay means shutdown, then retry policy.
// - Action 11: output off while fault persists, back on when gone.
// - Retry field sets restart count; zero none, seven forever.
// - Zero retries keeps output off until the fault is cleared.
// - Time field gives 1, 2, 4, 8 or 16 units for delay and retry.
module ocr_fault_response
   import ocr_pkg::*;
#(
   parameter int UNIT_CYC = UNIT_CYCLES
) (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic cfg_we_in,
   input wire logic [7:0] cfg_wdata_in,
   input wire logic overcurrent_in,
   input wire logic below_cutoff_in,
   input wire logic fault_clear_in,
   output logic [7:0] cfg_rdata_out,
   output logic output_en_out,
   output logic current_limit_out,
   output logic latched_off_out,
   output ocr_status_s status_out
);
   logic [7:0] overcurrent_response_config;
   ocr_state_e state;
   ocr_state_e next_state;
   logic [CNT_W-1:0] timer;
   logic [CNT_W-1:0] next_timer;
   logic [2:0] tries;
   logic [2:0] next_tries;
   logic [1:0] action;
   logic [2:0] retry_set;
   logic timer_done;

   // Delay or retry time in cycles for a multiplier code
   function automatic logic [CNT_W-1:0] span(input logic [2:0] code);
      logic [2:0] c;
      c = (code > TIME_CODE_MAX) ? TIME_CODE_MAX : code;
      span = CNT_W'(UNIT_CYC << c);
   endfunction

   // May another restart be attempted with this many already made
   function automatic logic may_retry(input logic [2:0] rs,
                                      input logic [2:0] n);
      may_retry = (rs == RETRY_FOREVER) || (n < rs);
   endfunction

   assign action = overcurrent_response_config[CFG_ACTION_MSB:CFG_ACTION_LSB];
   assign retry_set = overcurrent_response_config[CFG_RETRY_MSB:CFG_RETRY_LSB];
   assign timer_done = (timer <= 16'h0001);

   // Configuration register, written by the command handler
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         overcurrent_response_config <= CFG_RESET;
      end else if (cfg_we_in) begin
         overcurrent_response_config <= cfg_wdata_in;
      end
   end

   // Response sequencing
   always_comb begin
      next_state = state;
      next_timer = (timer != '0) ? timer - 16'h0001 : timer;
      next_tries = tries;
      unique case (state)
         ST_RUN: begin
            if (overcurrent_in) begin
               unique case (action)
                  ACT_IGNORE: next_state = ST_LIMIT;
                  ACT_CC_LV: next_state = ST_LIMIT;
                  ACT_DELAY: begin
                     next_state = ST_LIMIT;
                     next_timer = span(overcurrent_response_config[2:0]);
                  end
                  ACT_DISABLE: next_state = ST_OFF;
               endcase
            end
         end
         ST_LIMIT: begin
            if (!overcurrent_in) begin
               next_state = ST_RUN;
               next_tries = 3'h0;
            end else if ((action == ACT_CC_LV && below_cutoff_in) ||
                         (action == ACT_DELAY && timer_done)) begin
               next_state = ST_OFF;
            end else if (action == ACT_DISABLE) begin
               next_state = ST_OFF;
            end
         end
         ST_OFF: begin
            if (action == ACT_DISABLE) begin
               if (!overcurrent_in) begin
                  next_state = ST_RUN;
               end
            end else if (may_retry(retry_set, tries)) begin
               next_state = ST_WAIT;
               next_timer = span(overcurrent_response_config[2:0]);
            end
            // Zero retries: stay off until cleared
         end
         ST_WAIT: begin
            if (timer_done) begin
               next_state = ST_RUN;
               if (tries != RETRY_FOREVER) begin
                  next_tries = tries + 3'h1;
               end
            end
         end
      endcase
      if (fault_clear_in) begin
         next_state = ST_RUN;
         next_tries = 3'h0;
         next_timer = '0;
      end
   end

   // State, timer and retry count
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         state <= ST_RUN;
         timer <= '0;
         tries <= 3'h0;
      end else begin
         state <= next_state;
         timer <= next_timer;
         tries <= next_tries;
      end
   end

   // Registered outputs, computed from the next state
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         output_en_out <= 1'b1;
         current_limit_out <= 1'b0;
         latched_off_out <= 1'b0;
         cfg_rdata_out <= CFG_RESET;
         status_out <= '{output_en: 1'b1, current_limit: 1'b0,
                         latched_off: 1'b0};
      end else begin
         output_en_out <= (next_state inside {ST_RUN, ST_LIMIT});
         current_limit_out <= (next_state == ST_LIMIT);
         latched_off_out <= (next_state == ST_OFF) && (action != ACT_DISABLE);
         cfg_rdata_out <= cfg_we_in ? cfg_wdata_in
                                    : overcurrent_response_config;
         status_out.output_en <= (next_state inside {ST_RUN, ST_LIMIT});
         status_out.current_limit <= (next_state == ST_LIMIT);
         status_out.latched_off <= (next_state == ST_OFF) &&
                                   (action != ACT_DISABLE);
      end
   end

   // Ignore action never turns the output off while it holds
   a_ignore_keeps_on: assert property (
      @(posedge mclk_in) disable iff (reset_in)
      (state == ST_LIMIT && action == ACT_IGNORE && !fault_clear_in &&
       !cfg_we_in) |=> output_en_out)
      else $error("ignore action dropped the output");

   // Low voltage under action 01 shuts the output
   a_lv_cutoff_off: assert property (
      @(posedge mclk_in) disable iff (reset_in)
      (state == ST_LIMIT && action == ACT_CC_LV && overcurrent_in &&
       below_cutoff_in && !fault_clear_in) |=> !output_en_out)
      else $error("low voltage did not shut output");

   // Delay action arms the timer from the time field
   a_delay_arm: assert property (
      @(posedge mclk_in) disable iff (reset_in)
      (state == ST_RUN && overcurrent_in && action == ACT_DELAY &&
       !fault_clear_in) |=> (timer == span($past(
       overcurrent_response_config[2:0])) && current_limit_out))
      else $error("delay timer not armed");

   // Delay expiry under limiting shuts down
   a_delay_expire: assert property (
      @(posedge mclk_in) disable iff (reset_in)
      (state == ST_LIMIT && action == ACT_DELAY && timer_done &&
       overcurrent_in && !fault_clear_in) |=> state == ST_OFF)
      else $error("delay expiry did not shut down");

   // Disable action turns the output back on once the fault is gone
   a_disable_follow: assert property (
      @(posedge mclk_in) disable iff (reset_in)
      (state == ST_OFF && action == ACT_DISABLE && !overcurrent_in &&
       !cfg_we_in) |=> output_en_out)
      else $error("output not resumed after fault");

   // Once the restarts are used up the output stays latched off; a
   // lowered retry field must not let a stale count slip through
   a_retry_bound: assert property (
      @(posedge mclk_in) disable iff (reset_in)
      (state == ST_OFF && action != ACT_DISABLE &&
       retry_set != RETRY_FOREVER && tries >= retry_set &&
       !fault_clear_in) |=> state == ST_OFF)
      else $error("restart made past the retry limit");

   // No retry setting holds off until clear
   a_no_retry_hold: assert property (
      @(posedge mclk_in) disable iff (reset_in)
      (state == ST_OFF && retry_set == RETRY_NONE && action != ACT_DISABLE
       && !fault_clear_in && !cfg_we_in) |=> state == ST_OFF)
      else $error("restart made with zero retries");

   // Clear restarts everything
   a_clear_fresh: assert property (
      @(posedge mclk_in) disable iff (reset_in)
      fault_clear_in |=> (tries == 3'h0 && state == ST_RUN))
      else $error("clear did not reset retry state");

   // A granted restart waits one programmed retry interval
   a_retry_arm: assert property (
      @(posedge mclk_in) disable iff (reset_in)
      (state == ST_OFF && action != ACT_DISABLE && !fault_clear_in &&
       may_retry(retry_set, tries)) |=> (state == ST_WAIT &&
       timer == span($past(overcurrent_response_config[2:0]))))
      else $error("retry wait not armed");

   // The end of the retry interval turns the output back on
   a_wait_restart: assert property (
      @(posedge mclk_in) disable iff (reset_in)
      (state == ST_WAIT && timer_done && !fault_clear_in) |=>
      (output_en_out && state == ST_RUN))
      else $error("no restart after retry interval");
endmodule // ocr_fault_response

/* File: tb/ocr_host.sv */
// Host model: writes the response configuration byte.
// Assumes the bench calls write_cfg from its main sequence.
`timescale 1ns/1ps
module ocr_host (
   input wire logic mclk_in,
   output logic cfg_we_out,
   output logic [7:0] cfg_wdata_out
);
   // Idle bus at time zero
   initial begin
      cfg_we_out = 1'b0;
      cfg_wdata_out = 8'h00;
   end
   // One-cycle strobe; stale data is inverted so it is never trusted
   task automatic write_cfg(input logic [7:0] v);
      @(posedge mclk_in);
      cfg_we_out <= 1'b1;
      cfg_wdata_out <= v;
      @(posedge mclk_in);
      cfg_we_out <= 1'b0;
      cfg_wdata_out <= ~v;
      #1;
   endtask
endmodule // ocr_host

/* File: tb/tb_ocr_fault_response.sv */
// Bench for the overcurrent fault response block.
// Assumes a short time unit so every delay code fits a quick run.
`timescale 1ns/1ps
module tb_ocr_fault_response;
   import ocr_pkg::*;
   localparam int UC = 2;
   logic mclk_in = 1'b0;
   logic reset_in = 1'b1;
   logic oc = 1'b0;
   logic below = 1'b0;
   logic clr = 1'b0;
   logic cfg_we;
   logic [7:0] cfg_wdata;
   logic [7:0] cfg_rdata;
   ocr_status_s st;
   logic en;
   logic lim;
   logic lat;
   int failures = 0;
   int n_checks = 0;
   logic [31:0] seed = 32'hffc2;
   // Free-running clock
   always #50 mclk_in = ~mclk_in;
   ocr_host ocr_host_inst (.mclk_in(mclk_in), .cfg_we_out(cfg_we),
      .cfg_wdata_out(cfg_wdata));
   ocr_fault_response #(.UNIT_CYC(UC)) ocr_fault_response_inst (
      .mclk_in(mclk_in), .reset_in(reset_in), .cfg_we_in(cfg_we),
      .cfg_wdata_in(cfg_wdata), .overcurrent_in(oc),
      .below_cutoff_in(below), .fault_clear_in(clr),
      .cfg_rdata_out(cfg_rdata), .output_en_out(en),
      .current_limit_out(lim), .latched_off_out(lat), .status_out(st));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Delay span in cycles; codes above 4 saturate
   function automatic int span(input int c);
      return UC << ((c > 4) ? 4 : c);
   endfunction
   task automatic stop_test;
      if (failures == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk_cfg(input logic [7:0] exp);
      n_checks++;
      if (cfg_rdata !== exp) begin
         failures++;
         $display("[FAIL] %0t cfg %h exp %h", $time, cfg_rdata, exp);
      end
   endtask
   // Status order is {output_en, current_limit, latched_off}
   task automatic chk_st(input logic [2:0] exp);
      n_checks++;
      if (st !== exp || {en, lim, lat} !== exp) begin
         failures++;
         $display("[FAIL] %0t status %b pins %b exp %b", $time, st,
            {en, lim, lat}, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   task automatic drv(input logic o, input logic b, input logic c);
      @(posedge mclk_in);
      oc <= o;
      below <= b;
      clr <= c;
   endtask
   // Fault gone, then a clear pulse; output must come back
   task automatic clear_all;
      drv(1'b0, 1'b0, 1'b0);
      drv(1'b0, 1'b0, 1'b1);
      drv(1'b0, 1'b0, 1'b0);
      cyc(1);
      chk_st(3'b100);
   endtask
   // Hang guard
   initial begin
      #(3000 * 100);
      failures++;
      stop_test();
   end
   // Main sequence
   initial begin
      repeat (6) @(posedge mclk_in);
      reset_in <= 1'b0;
      cyc(1);
      chk_cfg(CFG_RESET);
      chk_st(3'b100);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         ocr_host_inst.write_cfg(seed[7:0]);
         chk_cfg(seed[7:0]);
      end
      ocr_host_inst.write_cfg({ACT_IGNORE, RETRY_NONE, 3'h0});
      drv(1'b1, 1'b1, 1'b0);
      cyc(40);
      chk_st(3'b110);
      ocr_host_inst.write_cfg({ACT_DISABLE, RETRY_NONE, 3'h0});
      drv(1'b1, 1'b0, 1'b0);
      cyc(30);
      chk_st(3'b000);
      drv(1'b0, 1'b0, 1'b0);
      cyc(1);
      chk_st(3'b100);
      drv(1'b1, 1'b0, 1'b0);
      cyc(1);
      chk_st(3'b000);
      drv(1'b0, 1'b0, 1'b0);
      cyc(1);
      chk_st(3'b100);
      for (int c = 0; c < 5; c++) begin
         ocr_host_inst.write_cfg({ACT_DELAY, RETRY_NONE, 3'(c)});
         drv(1'b1, 1'b0, 1'b0);
         cyc(span(c));
         chk_st(3'b110);
         cyc(1);
         chk_st(3'b001);
         drv(1'b0, 1'b0, 1'b0);
         cyc(20);
         chk_st(3'b001);
         clear_all();
      end
      ocr_host_inst.write_cfg({ACT_CC_LV, RETRY_NONE, 3'h4});
      drv(1'b1, 1'b0, 1'b0);
      cyc(50);
      chk_st(3'b110);
      drv(1'b1, 1'b1, 1'b0);
      cyc(1);
      chk_st(3'b001);
      clear_all();
      // One restart allowed; the second pass shows clear reset the count
      for (int k = 0; k < 2; k++) begin
         ocr_host_inst.write_cfg({ACT_DELAY, 3'h1, 3'h0});
         drv(1'b1, 1'b0, 1'b0);
         cyc(3);
         chk_st(3'b001);
         cyc(1);
         chk_st(3'b000);
         cyc(2);
         chk_st(3'b100);
         cyc(40);
         chk_st(3'b001);
         clear_all();
      end
      // Unlimited retries: still cycling after ten restarts, period 6
      ocr_host_inst.write_cfg({ACT_DELAY, RETRY_FOREVER, 3'h0});
      drv(1'b1, 1'b0, 1'b0);
      cyc(60);
      chk_st(3'b100);
      cyc(1);
      chk_st(3'b110);
      clear_all();
      stop_test();
   end
endmodule // tb_ocr_fault_response
